// ### dv/bws_bridge_window_status_regs_tb_top.sv
// Self-checking bench for the bridge window and status register block.
// Assumes the block's classic Wishbone slave and one clk domain at 200 MHz.
`timescale 1ns/1ps
`include "bws_regs.svh"
module bws_bridge_window_status_regs_tb_top
    import bws_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and clock
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    bws_word_t wbDatI = 32'h00000000, wbDatO, rdat, txnAddr = 32'h00000000;
    logic [15:0] ioBaseUpper = 16'h0000, ioLimitUpper = 16'h0000;
    logic parityRespEn = 1'b0, serrEn = 1'b0, txnValid = 1'b0, txnIsIo = 1'b0;
    logic [5:0] evVec = 6'h00;
    logic ioFwdValid, ioFwd, memFwdValid, memFwd;
    int errors = 0;
    int nChecks = 0;
    logic [15:0] ioLow;

    // Half period of 2.5 ns gives 200 MHz
    always #2.5 clk = ~clk;

`define CHK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

    bws_bridge_window_status_regs dut_u (
        .clk(clk), .nrst(nrst),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .ioBaseUpper(ioBaseUpper), .ioLimitUpper(ioLimitUpper),
        .parityRespEn(parityRespEn), .serrEn(serrEn),
        .evParityErr(evVec[0]), .evCplAbortSent(evVec[1]), .evCplAbortRcvd(evVec[2]),
        .evUnsupRcvd(evVec[3]), .evErrMsgSent(evVec[4]), .evPoisonRcvd(evVec[5]),
        .txnValid(txnValid), .txnIsIo(txnIsIo), .txnAddr(txnAddr),
        .ioFwdValid(ioFwdValid), .ioFwd(ioFwd), .memFwdValid(memFwdValid), .memFwd(memFwd)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Final verdict; also the exit for a bus wait that never ends
    task test_done;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input bws_word_t d);
        int i;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbSel <= s;
        wbDatI <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wbAck === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            $display("CHECK FAILED wb_ack_o expected 1 seen none");
            test_done();
        end
        rdat = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input bws_word_t exp);
        wb(1'b0, a, 4'hf, 32'h00000000);
        `CHK("wb_dat_o", exp, rdat)
    endtask : rd

    // One decode request; answer sampled the cycle after it is taken
    task automatic fwd(input logic io, input bws_word_t a, input logic exp);
        @(posedge clk);
        txnValid <= 1'b1;
        txnIsIo <= io;
        txnAddr <= a;
        @(posedge clk);
        txnValid <= 1'b0;
        @(posedge clk);
        `CHK("ioFwdValid", io, ioFwdValid)
        `CHK("memFwdValid", ~io, memFwdValid)
        if (io) `CHK("ioFwd", exp, ioFwd)
        else `CHK("memFwd", exp, memFwd)
    endtask : fwd

    // Events are one-cycle pulses on the clock edge
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        evVec <= m;
        @(posedge clk);
        evVec <= 6'h00;
    endtask : pulse

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_map;
        rd(`BWS_OFF_IO_STATUS, 32'h00000101);
        rd(`BWS_OFF_MEM_WINDOW, 32'h00000000);
        // Unmapped place must swallow writes and read zero
        wb(1'b1, 8'h24, 4'hf, 32'hffffffff);
        rd(8'h24, 32'h00000000);
        rd(`BWS_OFF_IO_STATUS, 32'h00000101);
        $display("done reset_map");
    endtask : t_reset_map

    task automatic t_io_regs;
        // All ones: indicator nibbles and hardwired status stay put
        wb(1'b1, `BWS_OFF_IO_STATUS, 4'hf, 32'hffffffff);
        rd(`BWS_OFF_IO_STATUS, 32'h0000f1f1);
        // Lanes are independent: base alone, then limit alone
        wb(1'b1, `BWS_OFF_IO_STATUS, 4'h1, 32'h00000030);
        rd(`BWS_OFF_IO_STATUS, 32'h0000f131);
        wb(1'b1, `BWS_OFF_IO_STATUS, 4'h2, 32'h00005000);
        rd(`BWS_OFF_IO_STATUS, 32'h00005131);
        ioLow = 16'h5131;
        $display("done io_regs");
    endtask : t_io_regs

    task automatic t_io_fwd;
        // Window 0001_3000 to 0001_5fff; edges one address either side
        ioBaseUpper <= 16'h0001;
        ioLimitUpper <= 16'h0001;
        fwd(1'b1, 32'h00012fff, 1'b0);
        fwd(1'b1, 32'h00013000, 1'b1);
        fwd(1'b1, 32'h00015fff, 1'b1);
        fwd(1'b1, 32'h00016000, 1'b0);
        fwd(1'b1, 32'h00023000, 1'b0);
        // Upper halves differ: range spans 0001_3000 to 0002_5fff
        ioLimitUpper <= 16'h0002;
        fwd(1'b1, 32'h00017000, 1'b1);
        fwd(1'b1, 32'h00025fff, 1'b1);
        $display("done io_fwd");
    endtask : t_io_fwd

    task automatic t_mem;
        // Reserved nibbles ignore the ones written into them
        wb(1'b1, `BWS_OFF_MEM_WINDOW, 4'hf, 32'h123f120f);
        rd(`BWS_OFF_MEM_WINDOW, 32'h12301200);
        fwd(1'b0, 32'h11ffffff, 1'b0);
        fwd(1'b0, 32'h12000000, 1'b1);
        fwd(1'b0, 32'h123fffff, 1'b1);
        fwd(1'b0, 32'h12400000, 1'b0);
        // Split lanes: base high byte and limit low nibble only
        wb(1'b1, `BWS_OFF_MEM_WINDOW, 4'h6, 32'hff5f34ff);
        rd(`BWS_OFF_MEM_WINDOW, 32'h12503400);
        $display("done mem");
    endtask : t_mem

    task automatic t_flags;
        // Gated events with both enables low must be ignored
        pulse(6'h11);
        rd(`BWS_OFF_IO_STATUS, {16'h0000, ioLow});
        parityRespEn <= 1'b1;
        serrEn <= 1'b1;
        pulse(6'h3f);
        rd(`BWS_OFF_IO_STATUS, {16'hf900, ioLow});
        // Zero in the clear lane keeps every flag
        wb(1'b1, `BWS_OFF_IO_STATUS, 4'h8, 32'h00000000);
        rd(`BWS_OFF_IO_STATUS, {16'hf900, ioLow});
        // Poison held across the clearing write must win
        @(posedge clk);
        evVec <= 6'h20;
        wb(1'b1, `BWS_OFF_IO_STATUS, 4'h8, 32'hff000000);
        evVec <= 6'h00;
        rd(`BWS_OFF_IO_STATUS, {16'hb800, ioLow});
        wb(1'b1, `BWS_OFF_IO_STATUS, 4'h8, 32'hff000000);
        rd(`BWS_OFF_IO_STATUS, {16'h3800, ioLow});
        // Read-only abort flags only leave on reset
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(`BWS_OFF_IO_STATUS, 32'h00000101);
        rd(`BWS_OFF_MEM_WINDOW, 32'h00000000);
        // One event at a time, so every flag shows at its own bit
        pulse(6'h04);
        rd(`BWS_OFF_IO_STATUS, 32'h10000101);
        pulse(6'h08);
        rd(`BWS_OFF_IO_STATUS, 32'h30000101);
        pulse(6'h02);
        rd(`BWS_OFF_IO_STATUS, 32'h38000101);
        pulse(6'h01);
        rd(`BWS_OFF_IO_STATUS, 32'h39000101);
        pulse(6'h10);
        rd(`BWS_OFF_IO_STATUS, 32'h79000101);
        pulse(6'h20);
        rd(`BWS_OFF_IO_STATUS, 32'hf9000101);
        $display("done flags");
    endtask : t_flags

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset_map();
        t_io_regs();
        t_io_fwd();
        t_mem();
        t_flags();
        test_done();
    end
endmodule : bws_bridge_window_status_regs_tb_top

// ### logic/bws_bridge_window_status_regs.sv
// Bridge I/O and memory window registers and secondary status flags, Wishbone slave.
// Assumes a classic Wishbone master that holds its request until ack, and
// one-cycle event pulses from the port logic, all on clk.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "bws_regs.svh"
module bws_bridge_window_status_regs
    import bws_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire bws_word_t wb_dat_i,
    output bws_word_t wb_dat_o,
    output logic wb_ack_o,
    // Upper I/O window halves and control enables
    input wire logic [15:0] ioBaseUpper,
    input wire logic [15:0] ioLimitUpper,
    input wire logic parityRespEn,
    input wire logic serrEn,
    // Secondary side events, one-cycle pulses
    input wire logic evParityErr,
    input wire logic evCplAbortSent,
    input wire logic evCplAbortRcvd,
    input wire logic evUnsupRcvd,
    input wire logic evErrMsgSent,
    input wire logic evPoisonRcvd,
    // Transaction to decode
    input wire logic txnValid,
    input wire logic txnIsIo,
    input wire bws_word_t txnAddr,
    // Forwarding decision, one cycle later
    output logic ioFwdValid,
    output logic ioFwd,
    output logic memFwdValid,
    output logic memFwd
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    bws_bus_state_t busState;
    bws_bus_state_t next_busState;
    logic next_ack;
    bws_word_t next_dat;
    logic commitWr;
    logic hitIo;
    logic hitMem;
    bws_word_t ioStatusWord;
    bws_word_t memWord;

    assign hitIo = (wb_adr_i == `BWS_OFF_IO_STATUS);
    assign hitMem = (wb_adr_i == `BWS_OFF_MEM_WINDOW);
    // Writes land on the edge the master samples ack
    assign commitWr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;

    // Ack one cycle after the request, dropped the cycle after
    always_comb begin
        next_busState = busState;
        next_ack = 1'b0;
        next_dat = wb_dat_o;
        unique case (busState)
            BWS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    next_busState = BWS_ACK;
                    next_ack = 1'b1;
                    // Unmapped offsets read as zero and still ack
                    if (hitIo) begin
                        next_dat = ioStatusWord;
                    end else if (hitMem) begin
                        next_dat = memWord;
                    end else begin
                        next_dat = `BWS_WORD_ZERO;
                    end
                end
            end
            BWS_ACK: begin
                next_busState = BWS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busState <= BWS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= `BWS_WORD_ZERO;
        end else begin
            busState <= next_busState;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ----------------------------------------------------------------
    // Window registers
    // ----------------------------------------------------------------
    logic [3:0] ioBase;
    logic [3:0] ioLimit;
    logic [11:0] memBase;
    logic [11:0] memLimit;
    logic [3:0] next_ioBase;
    logic [3:0] next_ioLimit;
    logic [11:0] next_memBase;
    logic [11:0] next_memLimit;

    // Byte lanes gate each field; read-only nibbles have no storage
    always_comb begin
        next_ioBase = ioBase;
        next_ioLimit = ioLimit;
        next_memBase = memBase;
        next_memLimit = memLimit;
        if (commitWr && hitIo) begin
            if (wb_sel_i[0]) begin
                next_ioBase = wb_dat_i[7:4];
            end
            if (wb_sel_i[1]) begin
                next_ioLimit = wb_dat_i[15:12];
            end
        end
        if (commitWr && hitMem) begin
            // Field spans two lanes; a partial write updates only its own bits
            if (wb_sel_i[0]) begin
                next_memBase[3:0] = wb_dat_i[7:4];
            end
            if (wb_sel_i[1]) begin
                next_memBase[11:4] = wb_dat_i[15:8];
            end
            if (wb_sel_i[2]) begin
                next_memLimit[3:0] = wb_dat_i[23:20];
            end
            if (wb_sel_i[3]) begin
                next_memLimit[11:4] = wb_dat_i[31:24];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ioBase <= `BWS_IO_BASE_RESET;
            ioLimit <= `BWS_IO_LIMIT_RESET;
            memBase <= `BWS_MEM_BASE_RESET;
            memLimit <= `BWS_MEM_LIMIT_RESET;
        end else begin
            ioBase <= next_ioBase;
            ioLimit <= next_ioLimit;
            memBase <= next_memBase;
            memLimit <= next_memLimit;
        end
    end

    // ----------------------------------------------------------------
    // Secondary status flags
    // ----------------------------------------------------------------
    logic clrByte3;
    logic flParity;
    logic flSigAbort;
    logic flRcvAbort;
    logic flRcvUnsup;
    logic flSysErr;
    logic flPoison;

    assign clrByte3 = commitWr && hitIo && wb_sel_i[3];

    // Parity flag cannot set while response is disabled
    bws_status_flag #(.CLEARABLE(1'b1)) u_parity (
        .clk(clk),
        .nrst(nrst),
        .setEvt(evParityErr && parityRespEn),
        .clrWr(clrByte3 && wb_dat_i[`BWS_BIT_PARITY]),
        .flag(flParity)
    );

    // Abort flags are read-only, cleared by reset alone
    bws_status_flag #(.CLEARABLE(1'b0)) u_sig_abort (
        .clk(clk),
        .nrst(nrst),
        .setEvt(evCplAbortSent),
        .clrWr(1'b0),
        .flag(flSigAbort)
    );

    bws_status_flag #(.CLEARABLE(1'b0)) u_rcv_abort (
        .clk(clk),
        .nrst(nrst),
        .setEvt(evCplAbortRcvd),
        .clrWr(1'b0),
        .flag(flRcvAbort)
    );

    bws_status_flag #(.CLEARABLE(1'b0)) u_rcv_unsup (
        .clk(clk),
        .nrst(nrst),
        .setEvt(evUnsupRcvd),
        .clrWr(1'b0),
        .flag(flRcvUnsup)
    );

    bws_status_flag #(.CLEARABLE(1'b1)) u_sys_err (
        .clk(clk),
        .nrst(nrst),
        .setEvt(evErrMsgSent && serrEn),
        .clrWr(clrByte3 && wb_dat_i[`BWS_BIT_SYS_ERR]),
        .flag(flSysErr)
    );

    bws_status_flag #(.CLEARABLE(1'b1)) u_poison (
        .clk(clk),
        .nrst(nrst),
        .setEvt(evPoisonRcvd),
        .clrWr(clrByte3 && wb_dat_i[`BWS_BIT_POISON]),
        .flag(flPoison)
    );

    // Read words; hardwired zeros for legacy timing bits
    assign ioStatusWord = {flPoison, flSysErr, flRcvUnsup, flRcvAbort, flSigAbort,
                           2'b00, flParity, 1'b0, 1'b0, 1'b0, 5'b00000,
                           ioLimit, `BWS_IO_DECODE_32, ioBase, `BWS_IO_DECODE_32};
    assign memWord = {memLimit, 4'h0, memBase, 4'h0};

    // ----------------------------------------------------------------
    // Window decode
    // ----------------------------------------------------------------
    bws_word_t ioBottom;
    bws_word_t ioTop;
    bws_word_t memBottom;
    bws_word_t memTop;

    // Upper halves of the I/O window come from outside
    assign ioBottom = {ioBaseUpper, ioBase, `BWS_IO_LOW_ZERO};
    assign ioTop = {ioLimitUpper, ioLimit, `BWS_IO_LOW_ONES};
    assign memBottom = {memBase, `BWS_MEM_LOW_ZERO};
    assign memTop = {memLimit, `BWS_MEM_LOW_ONES};

    bws_range_match u_io_match (
        .clk(clk),
        .nrst(nrst),
        .valid(txnValid && txnIsIo),
        .addr(txnAddr),
        .bottom(ioBottom),
        .top(ioTop),
        .hitValid(ioFwdValid),
        .hit(ioFwd)
    );

    bws_range_match u_mem_match (
        .clk(clk),
        .nrst(nrst),
        .valid(txnValid && !txnIsIo),
        .addr(txnAddr),
        .bottom(memBottom),
        .top(memTop),
        .hitValid(memFwdValid),
        .hit(memFwd)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_io_indicator;
        @(posedge clk) disable iff (!nrst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && hitIo) |=>
            (wb_ack_o && wb_dat_o[3:0] == 4'h1 && wb_dat_o[11:8] == 4'h1);
    endproperty
    a_io_indicator: assert property (p_io_indicator)
        else $error("I/O decode indicator not 1h");

    property p_legacy_zero;
        @(posedge clk) disable iff (!nrst)
        (wb_ack_o && hitIo) |-> (!wb_dat_o[21] && !wb_dat_o[23] && wb_dat_o[26:25] == 2'b00);
    endproperty
    a_legacy_zero: assert property (p_legacy_zero)
        else $error("legacy status bits not zero");

    property p_io_base_write;
        @(posedge clk) disable iff (!nrst)
        (commitWr && hitIo && wb_sel_i[0]) |=> (ioBase == $past(wb_dat_i[7:4]));
    endproperty
    a_io_base_write: assert property (p_io_base_write)
        else $error("I/O base write lost");

    property p_parity_gated;
        @(posedge clk) disable iff (!nrst)
        $rose(flParity) |-> ($past(evParityErr) && $past(parityRespEn));
    endproperty
    a_parity_gated: assert property (p_parity_gated)
        else $error("parity flag set without enabled event");

    property p_abort_sticky;
        @(posedge clk) disable iff (!nrst)
        (flSigAbort || flRcvAbort || flRcvUnsup) |=>
            (flSigAbort >= $past(flSigAbort) && flRcvAbort >= $past(flRcvAbort)
             && flRcvUnsup >= $past(flRcvUnsup));
    endproperty
    a_abort_sticky: assert property (p_abort_sticky)
        else $error("read-only abort flag cleared");

    property p_serr_gated;
        @(posedge clk) disable iff (!nrst)
        $rose(flSysErr) |-> ($past(evErrMsgSent) && $past(serrEn));
    endproperty
    a_serr_gated: assert property (p_serr_gated)
        else $error("system error flag set without enable");

    property p_ack_one_cycle;
        @(posedge clk) disable iff (!nrst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("ack timing wrong");

endmodule : bws_bridge_window_status_regs

// ### logic/bws_pkg.sv
// Types shared by the bridge window and status register block.
// Assumes nothing of its surroundings.
package bws_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [31:0] bws_word_t;
    typedef enum logic {BWS_IDLE, BWS_ACK} bws_bus_state_t;

endpackage : bws_pkg

// ### logic/bws_range_match.sv
// Registered address window compare: hit when bottom <= addr <= top.
// Assumes addr, bottom and top are stable in the cycle valid is high.
`timescale 1ns/1ps
module bws_range_match
    import bws_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request
    input wire logic valid,
    input wire bws_word_t addr,
    input wire bws_word_t bottom,
    input wire bws_word_t top,
    // Answer
    output logic hitValid,
    output logic hit
);

    logic next_hitValid;
    logic next_hit;

    // Window compare, one cycle of latency
    always_comb begin
        next_hitValid = valid;
        next_hit = valid && (addr >= bottom) && (addr <= top);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hitValid <= 1'b0;
            hit <= 1'b0;
        end else begin
            hitValid <= next_hitValid;
            hit <= next_hit;
        end
    end

    property p_in_range_forwards;
        @(posedge clk) disable iff (!nrst)
        (valid && addr >= bottom && addr <= top) |=> (hit && hitValid);
    endproperty
    a_in_range_forwards: assert property (p_in_range_forwards)
        else $error("address inside window not forwarded");

    property p_out_of_range_blocked;
        @(posedge clk) disable iff (!nrst)
        (valid && (addr < bottom || addr > top)) |=> !hit;
    endproperty
    a_out_of_range_blocked: assert property (p_out_of_range_blocked)
        else $error("address outside window forwarded");

endmodule : bws_range_match

// ### logic/bws_regs.svh
// Offsets, field positions, reset values and constants of the bridge window registers.
// Assumes byte addressing on a 32-bit Wishbone slave, one aligned word per register.
`ifndef BWS_REGS_SVH
`define BWS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BWS_OFF_IO_STATUS 8'h1c
`define BWS_OFF_MEM_WINDOW 8'h20

// ----------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------
`define BWS_IO_DECODE_32 4'h1
`define BWS_IO_BASE_RESET 4'h0
`define BWS_IO_LIMIT_RESET 4'h0
`define BWS_MEM_BASE_RESET 12'h000
`define BWS_MEM_LIMIT_RESET 12'h000
`define BWS_IO_LOW_ZERO 12'h000
`define BWS_IO_LOW_ONES 12'hfff
`define BWS_MEM_LOW_ZERO 20'h00000
`define BWS_MEM_LOW_ONES 20'hfffff
`define BWS_BIT_PARITY 24
`define BWS_BIT_SYS_ERR 30
`define BWS_BIT_POISON 31
`define BWS_WORD_ZERO 32'h00000000

`endif

// ### logic/bws_status_flag.sv
// One sticky status flag, optionally write-one-to-clear.
// Assumes setEvt and clrWr are one-cycle pulses in the clk domain.
`timescale 1ns/1ps
module bws_status_flag
    import bws_pkg::*;
#(
    parameter bit CLEARABLE = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Set and clear
    input wire logic setEvt,
    input wire logic clrWr,
    // Flag
    output logic flag
);

    logic next_flag;

    // Set beats clear so no event is lost
    always_comb begin
        next_flag = setEvt || (flag && !(CLEARABLE && clrWr));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    property p_set_wins;
        @(posedge clk) disable iff (!nrst)
        setEvt |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("set event lost");

    property p_clear_or_hold;
        @(posedge clk) disable iff (!nrst)
        (flag && !setEvt) |=> (flag == !(CLEARABLE && $past(clrWr)));
    endproperty
    a_clear_or_hold: assert property (p_clear_or_hold)
        else $error("flag clear or hold wrong");

endmodule : bws_status_flag
